// file: asrc_pkg.sv
// constants, modes, register map and state layouts of the analog speed reference conditioner
package asrc_pkg;

  // input signal formats; both channels share one encoding
  typedef enum logic [3:0] {
    ASRC_FMT_UNI          = 4'h0,  // 0..10 V unipolar
    ASRC_FMT_BI           = 4'h1,  // -10..10 V bipolar, channel 1 only
    ASRC_FMT_MA0_20       = 4'h2,  // 0..20 mA
    ASRC_FMT_MA4_20_TRIP  = 4'h3,  // 4..20 mA, trip on loss
    ASRC_FMT_MA4_20_RAMP  = 4'h4,  // 4..20 mA, ramp to stop on loss
    ASRC_FMT_MA20_4_TRIP  = 4'h5,  // 20..4 mA, trip on loss
    ASRC_FMT_MA20_4_RAMP  = 4'h6,  // 20..4 mA, ramp to stop on loss
    ASRC_FMT_INV          = 4'h7,  // 10..0 V inverted, channel 1 only
    ASRC_FMT_THERM        = 4'h8   // motor_thermistor_mode, channel 2 only
  } asrc_fmt_t;

  // register byte addresses
  localparam logic [11:0] ASRC_REG_CTRL    = 12'h000;
  localparam logic [11:0] ASRC_REG_FMT1    = 12'h004;
  localparam logic [11:0] ASRC_REG_OFFSET1 = 12'h008;
  localparam logic [11:0] ASRC_REG_SCALE1  = 12'h00C;
  localparam logic [11:0] ASRC_REG_FMT2    = 12'h010;
  localparam logic [11:0] ASRC_REG_PRESET4 = 12'h014;
  localparam logic [11:0] ASRC_REG_RATED   = 12'h018;
  localparam logic [11:0] ASRC_REG_MAXSPD  = 12'h01C;
  localparam logic [11:0] ASRC_REG_STATUS  = 12'h020;
  localparam logic [11:0] ASRC_REG_MASK    = 12'h024;
  localparam logic [11:0] ASRC_REG_DEMAND  = 12'h028;
  localparam logic [11:0] ASRC_REG_FAULT   = 12'h02C;
  localparam logic [11:0] ASRC_REG_AIN2    = 12'h030;

  // field positions
  localparam int ASRC_CTRL_PRESET = 0;
  localparam int ASRC_CTRL_LOCAL  = 1;
  localparam int ASRC_CTRL_REFSEL = 2;
  localparam int ASRC_EV_TRIP1    = 0;
  localparam int ASRC_EV_TRIP2    = 1;
  localparam int ASRC_EV_RAMP1    = 2;
  localparam int ASRC_EV_RAMP2    = 3;
  localparam int ASRC_DEM_REVERSE = 16;

  // values after reset, in 0.1 % or 0.1 Hz/rpm units
  localparam logic [15:0] ASRC_RST_OFFSET1 = 16'h0000;  // 0.0 %
  localparam logic [15:0] ASRC_RST_SCALE1  = 16'h03E8;  // 100.0 %
  localparam logic [15:0] ASRC_RST_PRESET4 = 16'h00F0;  // 24.0 Hz/rpm
  localparam logic [15:0] ASRC_RST_RATED   = 16'h0000;
  localparam logic [15:0] ASRC_RST_MAXSPD  = 16'h01F4;  // plain default
  localparam logic [3:0]  ASRC_RST_MASK    = 4'h0;

  // level scale: codes are per-mille of full scale (10 V or 20 mA)
  localparam logic [26:0] ASRC_FULL_SCALE = 27'h00003E8;  // 100.0 %
  localparam logic [17:0] ASRC_LIVE_ZERO  = 18'h000C8;    // 4 mA
  localparam logic [17:0] ASRC_LOSS_LEVEL = 18'h00096;    // 3 mA
  localparam logic [15:0] ASRC_FAULT_LOSS = 16'h0007;     // current-loss fault code

  // current-loop formats that trip on loss
  function automatic logic asrc_is_trip(asrc_fmt_t f);
    return (f == ASRC_FMT_MA4_20_TRIP) || (f == ASRC_FMT_MA20_4_TRIP);
  endfunction

  // current-loop formats that ramp to stop on loss
  function automatic logic asrc_is_ramp(asrc_fmt_t f);
    return (f == ASRC_FMT_MA4_20_RAMP) || (f == ASRC_FMT_MA20_4_RAMP);
  endfunction

  // state of one channel conditioner
  typedef struct packed {
    logic [11:0]        s1;
    logic [11:0]        s2;
    logic [11:0]        s3;
    logic [11:0]        held;
    logic signed [10:0] pct;
    logic               loss;
  } asrc_cond_state_t;

  // state of the top level
  typedef struct packed {
    logic               preset_en;
    logic               local_mode;
    logic               ref_sel;
    asrc_fmt_t          fmt1;
    asrc_fmt_t          fmt2;
    logic [15:0]        offset1;
    logic [15:0]        scale1;
    logic [15:0]        preset4;
    logic [15:0]        rated;
    logic [15:0]        max_spd;
    logic [3:0]         status;
    logic [3:0]         mask;
    logic               trip;
    logic [15:0]        fault_code;
    logic               ramp_stop;
    logic [15:0]        speed;
    logic               reverse;
    logic               speed_in_rpm;
    logic [10:0]        ain2_pct;
    logic               irq;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } asrc_top_state_t;

endpackage

// file: asrc_cond_if.sv
// signals between the top level and one channel conditioner
`timescale 1ns/100ps
interface asrc_cond_if;
  logic [11:0]          raw;
  asrc_pkg::asrc_fmt_t  fmt;
  logic [15:0]          offset;
  logic [15:0]          scale;
  logic signed [10:0]   pct;
  logic                 loss;

  modport top_side (output raw, output fmt, output offset, output scale, input pct, input loss);
  modport cond_side (input raw, input fmt, input offset, input scale, output pct, output loss);
endinterface

// file: asrc_cond.sv
// one analog channel: pin synchroniser, format decode, offset, scaling and clamping
`timescale 1ns/100ps
module asrc_cond (
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  // channel
  asrc_cond_if.cond_side ch
);
  localparam logic signed [17:0] FULL   = 18'(asrc_pkg::ASRC_FULL_SCALE);
  localparam logic signed [35:0] FULL36 = 36'(asrc_pkg::ASRC_FULL_SCALE);

  asrc_pkg::asrc_cond_state_t r;
  asrc_pkg::asrc_cond_state_t next;
  logic signed [17:0]          x;
  logic signed [17:0]          t;
  logic signed [17:0]          lvl;
  logic signed [17:0]          diff;
  logic signed [17:0]          sc;
  logic signed [35:0]          prod;
  logic signed [35:0]          cval;
  logic signed [17:0]          lo;
  logic signed [17:0]          clip;
  logic signed [17:0]          outv;
  logic                        live_zero;
  logic                        inverted;

  // sync, decode, condition
  always_comb
  begin
    next = r;
    next.s1 = ch.raw;
    next.s2 = r.s1;
    next.s3 = r.s2;
    if (r.s2 == r.s3)
    begin
      next.held = r.s3;
    end
    x = {{6{r.held[11]}}, r.held};
    t = x - $signed(asrc_pkg::ASRC_LIVE_ZERO);
    live_zero = asrc_pkg::asrc_is_trip(ch.fmt) || asrc_pkg::asrc_is_ramp(ch.fmt);
    inverted = (ch.fmt == asrc_pkg::ASRC_FMT_INV) || (ch.fmt == asrc_pkg::ASRC_FMT_MA20_4_TRIP)
            || (ch.fmt == asrc_pkg::ASRC_FMT_MA20_4_RAMP);
    // 4..20 mA span maps onto 0..100 %
    lvl = live_zero ? (((t <<< 2) + t) >>> 2) : x;
    // offset first, then scaling [RULE17] [RULE9] [RULE10]
    diff = lvl - {{2{ch.offset[15]}}, ch.offset};
    sc = {2'b00, ch.scale};
    prod = diff * sc;
    cval = prod / FULL36;
    // only bipolar keeps negative demand [RULE2] [RULE3]
    lo = (ch.fmt == asrc_pkg::ASRC_FMT_BI) ? -FULL : 18'sh00000;
    if (cval < 36'(lo))
    begin
      clip = lo;
    end
    else if (cval > FULL36)
    begin
      clip = FULL;
    end
    else
    begin
      clip = 18'(cval);
    end
    // inverted ranges run at full demand at or below zero [RULE8]
    outv = inverted ? (FULL - clip) : clip;
    next.pct = (ch.fmt == asrc_pkg::ASRC_FMT_THERM) ? 11'sh000 : 11'(outv);  // [RULE13]
    // loop below 3 mA is a lost signal [RULE4] [RULE12]
    next.loss = live_zero && (x < $signed(asrc_pkg::ASRC_LOSS_LEVEL));
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next;
  end

  assign ch.pct  = r.pct;
  assign ch.loss = r.loss;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_uni_clamp_zero: assert property ( // [RULE2]
    (ch.fmt == asrc_pkg::ASRC_FMT_UNI) && (cval < 0) |=> (r.pct == 11'sh000))
    else $error("unipolar negative not clamped");
  a_bipolar_reverse: assert property ( // [RULE3]
    (ch.fmt == asrc_pkg::ASRC_FMT_BI) && (cval < 0) |=> (r.pct < 0))
    else $error("bipolar negative lost");
  a_inverted_full: assert property ( // [RULE8]
    (ch.fmt == asrc_pkg::ASRC_FMT_INV) && (cval <= 0) |=> (r.pct == 11'(FULL)))
    else $error("inverted not at full");
endmodule

// file: asrc_top.sv
// analog speed reference conditioner: two analog channels, preset speed, APB registers
//
// Functional notes
// [RULE1] Input 1 format select, default 0..10 V unipolar, six further variants; the code accepts seven.
// [RULE2] Unipolar voltage: conditioned reference below zero holds zero speed.
// [RULE3] Bipolar voltage: conditioned reference below zero commands reverse rotation.
// [RULE4] 4..20 mA trip variant: loop below 3 mA trips with current-loss code.
// [RULE5] 4..20 mA ramp variant: loop below 3 mA ramps to stop, no trip.
// [RULE6] 20..4 mA trip variant: loop below 3 mA trips with current-loss code.
// [RULE7] 20..4 mA ramp variant: loop below 3 mA ramps to stop.
// [RULE8] Inverted 10..0 V: conditioned reference at or below zero gives maximum speed.
// [RULE9] Offset in percent of full scale, default zero, subtracted from input.
// [RULE10] Scaling factor in percent of full scale multiplies input, default 100 %.
// [RULE11] Conditioned 100 % maps to maximum speed limit.
// [RULE12] Input 2 format select, default 0..10 V, current variants, same 3 mA threshold.
// [RULE13] Input 2 may serve as motor thermistor, then not a speed reference.
// [RULE14] Preset speed four held as output frequency, default 24.0 Hz or rpm.
// [RULE15] Active preset overrides analog reference; ignored in local control mode.
// [RULE16] Preset unit is Hz if rated speed zero, else rpm; negative reverses.
// [RULE17] Offset applied before scaling; zero comparisons use conditioned result.
// [RULE18] Input 2 loop loss in trip variant reports same current-loss code.
`timescale 1ns/100ps
module asrc_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // analog front end codes, per-mille of full scale
  input  wire logic [11:0] ain1_code,
  input  wire logic [11:0] ain2_code,
  // drive demand
  output logic [15:0]      speed,
  output logic             reverse,
  output logic             speed_in_rpm,
  output logic             ramp_stop,
  output logic             trip,
  output logic [15:0]      fault_code,
  output logic [10:0]      ain2_level,
  // interrupt
  output logic             irq
);
  localparam asrc_pkg::asrc_top_state_t RST = '{
    preset_en:    1'b0,
    local_mode:   1'b0,
    ref_sel:      1'b0,
    fmt1:         asrc_pkg::ASRC_FMT_UNI,
    fmt2:         asrc_pkg::ASRC_FMT_UNI,
    offset1:      asrc_pkg::ASRC_RST_OFFSET1,
    scale1:       asrc_pkg::ASRC_RST_SCALE1,
    preset4:      asrc_pkg::ASRC_RST_PRESET4,
    rated:        asrc_pkg::ASRC_RST_RATED,
    max_spd:      asrc_pkg::ASRC_RST_MAXSPD,
    status:       4'h0,
    mask:         asrc_pkg::ASRC_RST_MASK,
    trip:         1'b0,
    fault_code:   16'h0000,
    ramp_stop:    1'b0,
    speed:        16'h0000,
    reverse:      1'b0,
    speed_in_rpm: 1'b0,
    ain2_pct:     11'h000,
    irq:          1'b0,
    pready:       1'b0,
    pslverr:      1'b0,
    prdata:       32'h00000000
  };

  asrc_pkg::asrc_top_state_t r;
  asrc_pkg::asrc_top_state_t next;
  logic                      setup;
  logic                      access;
  logic                      wr;
  logic                      miss;
  logic [31:0]               rdata;
  logic [3:0]                clr;
  logic [3:0]                ev;
  logic                      use_ch2;
  logic                      ramp_now;
  logic                      preset_on;
  logic [15:0]               preset_mag;
  logic signed [10:0]        ref_pct;
  logic [10:0]               pmag;
  logic [26:0]               prod;
  asrc_pkg::asrc_fmt_t       wfmt;

  asrc_cond_if ch1_if ();
  asrc_cond_if ch2_if ();

  // channel 1 takes its own offset and scaling; channel 2 passes through unscaled
  assign ch1_if.raw    = ain1_code;
  assign ch1_if.fmt    = r.fmt1;
  assign ch1_if.offset = r.offset1;
  assign ch1_if.scale  = r.scale1;
  assign ch2_if.raw    = ain2_code;
  assign ch2_if.fmt    = r.fmt2;
  assign ch2_if.offset = 16'h0000;
  assign ch2_if.scale  = asrc_pkg::ASRC_RST_SCALE1;

  // conditioner for input 1
  asrc_cond u_ch1 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ch      (ch1_if.cond_side)
  );

  // conditioner for input 2
  asrc_cond u_ch2 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ch      (ch2_if.cond_side)
  );

  // register access, events and speed demand
  always_comb
  begin
    next = r;
    setup = psel & ~penable;
    access = psel & penable & r.pready;
    wr = access & pwrite;
    miss = 1'b0;
    rdata = 32'h00000000;
    clr = 4'h0;
    wfmt = asrc_pkg::asrc_fmt_t'(pwdata[3:0]);
    // zero wait states: ready in the first access cycle
    next.pready = setup;
    unique case (paddr)
      asrc_pkg::ASRC_REG_CTRL:
      begin
        rdata[asrc_pkg::ASRC_CTRL_PRESET] = r.preset_en;
        rdata[asrc_pkg::ASRC_CTRL_LOCAL] = r.local_mode;
        rdata[asrc_pkg::ASRC_CTRL_REFSEL] = r.ref_sel;
        if (wr)
        begin
          next.preset_en = pwdata[asrc_pkg::ASRC_CTRL_PRESET];
          next.local_mode = pwdata[asrc_pkg::ASRC_CTRL_LOCAL];
          next.ref_sel = pwdata[asrc_pkg::ASRC_CTRL_REFSEL];
        end
      end
      asrc_pkg::ASRC_REG_FMT1:
      begin
        rdata[3:0] = r.fmt1;
        // input 1 has no thermistor mode [RULE1]
        if (wr && (pwdata[3:0] <= asrc_pkg::ASRC_FMT_INV))
          next.fmt1 = wfmt;
      end
      asrc_pkg::ASRC_REG_OFFSET1:
      begin
        rdata[15:0] = r.offset1;
        if (wr)
          next.offset1 = pwdata[15:0];  // [RULE9]
      end
      asrc_pkg::ASRC_REG_SCALE1:
      begin
        rdata[15:0] = r.scale1;
        if (wr)
          next.scale1 = pwdata[15:0];  // [RULE10]
      end
      asrc_pkg::ASRC_REG_FMT2:
      begin
        rdata[3:0] = r.fmt2;
        // input 2 has no bipolar or inverted voltage [RULE12] [RULE13]
        if (wr && (pwdata[3:0] <= asrc_pkg::ASRC_FMT_THERM)
            && (wfmt != asrc_pkg::ASRC_FMT_BI) && (wfmt != asrc_pkg::ASRC_FMT_INV))
          next.fmt2 = wfmt;
      end
      asrc_pkg::ASRC_REG_PRESET4:
      begin
        rdata[15:0] = r.preset4;
        if (wr)
          next.preset4 = pwdata[15:0];  // [RULE14]
      end
      asrc_pkg::ASRC_REG_RATED:
      begin
        rdata[15:0] = r.rated;
        if (wr)
          next.rated = pwdata[15:0];
      end
      asrc_pkg::ASRC_REG_MAXSPD:
      begin
        rdata[15:0] = r.max_spd;
        if (wr)
          next.max_spd = pwdata[15:0];
      end
      asrc_pkg::ASRC_REG_STATUS:
      begin
        rdata[3:0] = r.status;
        if (wr)
          clr = pwdata[3:0];
      end
      asrc_pkg::ASRC_REG_MASK:
      begin
        rdata[3:0] = r.mask;
        if (wr)
          next.mask = pwdata[3:0];
      end
      asrc_pkg::ASRC_REG_DEMAND:
      begin
        rdata[15:0] = r.speed;
        rdata[asrc_pkg::ASRC_DEM_REVERSE] = r.reverse;
      end
      asrc_pkg::ASRC_REG_FAULT:
      begin
        rdata[15:0] = r.fault_code;
      end
      asrc_pkg::ASRC_REG_AIN2:
      begin
        rdata[10:0] = r.ain2_pct;
      end
      default:
      begin
        miss = 1'b1;
      end
    endcase
    // read data and error are latched in the setup cycle
    if (setup)
    begin
      next.prdata = rdata;
    end
    next.pslverr = setup & miss;

    // loop-loss events per channel and variant
    ev[asrc_pkg::ASRC_EV_TRIP1] = ch1_if.loss & asrc_pkg::asrc_is_trip(r.fmt1);  // [RULE4] [RULE6]
    ev[asrc_pkg::ASRC_EV_TRIP2] = ch2_if.loss & asrc_pkg::asrc_is_trip(r.fmt2);  // [RULE18]
    ev[asrc_pkg::ASRC_EV_RAMP1] = ch1_if.loss & asrc_pkg::asrc_is_ramp(r.fmt1);  // [RULE5] [RULE7]
    ev[asrc_pkg::ASRC_EV_RAMP2] = ch2_if.loss & asrc_pkg::asrc_is_ramp(r.fmt2);
    // sticky status, a new event beats a write-one clear
    next.status = (r.status & ~clr) | ev;
    next.irq = |(next.status & next.mask);
    // trip holds until both trip bits are cleared [RULE4] [RULE6] [RULE18]
    next.trip = next.status[asrc_pkg::ASRC_EV_TRIP1] | next.status[asrc_pkg::ASRC_EV_TRIP2];
    next.fault_code = next.trip ? asrc_pkg::ASRC_FAULT_LOSS : 16'h0000;

    // thermistor input never feeds the reference [RULE13]
    use_ch2 = r.ref_sel & (r.fmt2 != asrc_pkg::ASRC_FMT_THERM);
    ref_pct = use_ch2 ? ch2_if.pct : ch1_if.pct;
    ramp_now = use_ch2 ? ev[asrc_pkg::ASRC_EV_RAMP2] : ev[asrc_pkg::ASRC_EV_RAMP1];
    next.ramp_stop = ramp_now;  // [RULE5] [RULE7]
    next.ain2_pct = ch2_if.pct;

    // preset wins over analog unless in local mode [RULE15]
    preset_on = r.preset_en & ~r.local_mode;
    preset_mag = r.preset4[15] ? (16'h0000 - r.preset4) : r.preset4;
    pmag = ref_pct[10] ? (11'h000 - ref_pct) : ref_pct;
    // 100 % reaches the maximum speed limit [RULE11]
    prod = 27'(pmag) * 27'(r.max_spd);
    next.speed_in_rpm = (r.rated != 16'h0000);  // [RULE16]
    if (next.trip | ramp_now)
    begin
      next.speed = 16'h0000;
      next.reverse = 1'b0;
    end
    else if (preset_on)
    begin
      next.speed = preset_mag;
      next.reverse = r.preset4[15];  // [RULE16]
    end
    else
    begin
      next.speed = 16'(prod / asrc_pkg::ASRC_FULL_SCALE);
      next.reverse = ref_pct[10];  // [RULE3]
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      r <= RST;
    else
      r <= next;
  end

  // outputs straight from the state register
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign prdata       = r.prdata;
  assign speed        = r.speed;
  assign reverse      = r.reverse;
  assign speed_in_rpm = r.speed_in_rpm;
  assign ramp_stop    = r.ramp_stop;
  assign trip         = r.trip;
  assign fault_code   = r.fault_code;
  assign ain2_level   = r.ain2_pct;
  assign irq          = r.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_trip_fault_code: assert property ( // [RULE4]
    r.trip
    |-> (r.fault_code == asrc_pkg::ASRC_FAULT_LOSS))
    else $error("trip without loss code");
  a_loss4_trips: assert property ( // [RULE4]
    ch1_if.loss && (r.fmt1 == asrc_pkg::ASRC_FMT_MA4_20_TRIP)
    |=> r.trip && (r.speed == 16'h0000))
    else $error("4-20 loss did not trip");
  a_loss20_trips: assert property ( // [RULE6]
    ch1_if.loss && (r.fmt1 == asrc_pkg::ASRC_FMT_MA20_4_TRIP)
    |=> r.trip && (r.speed == 16'h0000))
    else $error("20-4 loss did not trip");
  a_loss4_ramps: assert property ( // [RULE5]
    ch1_if.loss && !r.ref_sel && (r.fmt1 == asrc_pkg::ASRC_FMT_MA4_20_RAMP)
    |=> r.ramp_stop && (r.speed == 16'h0000))
    else $error("4-20 loss did not ramp");
  a_loss20_ramps: assert property ( // [RULE7]
    ch1_if.loss && !r.ref_sel && (r.fmt1 == asrc_pkg::ASRC_FMT_MA20_4_RAMP)
    |=> r.ramp_stop)
    else $error("20-4 loss did not ramp");
  a_ch2_loss_code: assert property ( // [RULE18]
    ch2_if.loss && asrc_pkg::asrc_is_trip(r.fmt2)
    |=> (r.fault_code == asrc_pkg::ASRC_FAULT_LOSS))
    else $error("input 2 loss code wrong");
  a_preset_override: assert property ( // [RULE15]
    preset_on && !r.trip ##1 !r.trip && !r.ramp_stop
    |-> (r.speed == $past(preset_mag)))
    else $error("preset not applied");
  a_unit_select: assert property ( // [RULE16]
    $changed(r.rated)
    |=> (r.speed_in_rpm == (r.rated != 16'h0000)))
    else $error("speed unit wrong");
  a_apb_zero_wait: assert property ( // zero wait states, ready in the first access cycle
    psel && !penable
    |=> r.pready ##1 !r.pready || (psel && !penable))
    else $error("apb answer timing");

  // sticky status, input 2 reference, refused formats, thermistor and preset sign
  a_status_set_wins: assert property ( // [RULE4]
    ev[asrc_pkg::ASRC_EV_TRIP1]
    |=> r.status[asrc_pkg::ASRC_EV_TRIP1])
    else $error("trip event lost");
  a_ch2_ramp: assert property ( // [RULE12]
    ch2_if.loss && r.ref_sel && (r.fmt2 == asrc_pkg::ASRC_FMT_MA4_20_RAMP)
    |=> r.ramp_stop && (r.speed == 16'h0000))
    else $error("input 2 loss did not ramp");
  a_fmt1_refused: assert property ( // [RULE1]
    wr && (paddr == asrc_pkg::ASRC_REG_FMT1) && (pwdata[3:0] > asrc_pkg::ASRC_FMT_INV)
    |=> (r.fmt1 == $past(r.fmt1)))
    else $error("illegal input 1 format taken");
  a_therm_level_zero: assert property ( // [RULE13]
    (r.fmt2 == asrc_pkg::ASRC_FMT_THERM)
    |-> ##2 (r.ain2_pct == 11'h000))
    else $error("thermistor level not zero");
  a_preset_reverse: assert property ( // [RULE16]
    preset_on && r.preset4[15] && !next.trip && !ramp_now
    |=> r.reverse)
    else $error("negative preset not reversed");
endmodule

// file: asrc_src_model.sv
// analog reference source model driving both front end codes
`timescale 1ns/100ps
module asrc_src_model (
  // clock
  input  wire logic        sys_clk,
  // levels requested by the bench, per-mille of full scale
  input  wire logic [11:0] lvl1,
  input  wire logic [11:0] lvl2,
  // front end codes seen by the block
  output logic [11:0]      ain1_code,
  output logic [11:0]      ain2_code
);
  // source levels move just after a clock edge, like a sampled converter
  always_ff @(posedge sys_clk)
  begin
    ain1_code <= lvl1;
    ain2_code <= lvl2;
  end
endmodule

// file: testbench.sv
// self-checking bench of the analog speed reference conditioner
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [11:0] lvl1    = 12'h000;
  logic [11:0] lvl2    = 12'h000;
  wire  [11:0] ain1_code, ain2_code;
  wire  [31:0] prdata;
  wire  [15:0] speed, fault_code;
  wire  [10:0] ain2_level;
  wire         pready, pslverr, reverse, speed_in_rpm, ramp_stop, trip, irq;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors = 0;
  int          cmp_count  = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  asrc_src_model u_asrc_src_model (.sys_clk(sys_clk), .lvl1(lvl1), .lvl2(lvl2),
    .ain1_code(ain1_code), .ain2_code(ain2_code));
  asrc_top u_asrc_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ain1_code(ain1_code), .ain2_code(ain2_code), .speed(speed),
    .reverse(reverse), .speed_in_rpm(speed_in_rpm), .ramp_stop(ramp_stop), .trip(trip),
    .fault_code(fault_code), .ain2_level(ain2_level), .irq(irq));

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      $display("CHECK FAILED pready expected 1 seen timeout");
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask

  // new source levels, then let the sync and conditioning pipeline settle
  task automatic settle(input logic [11:0] l1, input logic [11:0] l2);
    lvl1 <= l1;
    lvl2 <= l2;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic spd(input logic [15:0] s, input logic r);
    chk("speed", {16'h0, s}, {16'h0, speed});
    chk("reverse", {31'h0, r}, {31'h0, reverse});
  endtask

  task automatic t_reset();
    rd("fmt1", asrc_pkg::ASRC_REG_FMT1, 32'h0);
    rd("offset1", asrc_pkg::ASRC_REG_OFFSET1, 32'h0);
    rd("scale1", asrc_pkg::ASRC_REG_SCALE1, 32'h3E8);
    rd("fmt2", asrc_pkg::ASRC_REG_FMT2, 32'h0);
    rd("preset4", asrc_pkg::ASRC_REG_PRESET4, 32'h0F0);
    rd("unmapped", 12'h040, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    $display("test reset done");
  endtask

  task automatic t_uni();
    wr(asrc_pkg::ASRC_REG_OFFSET1, 32'h0C8);
    settle(12'h2BC, 12'h000);
    spd(16'h0FA, 1'b0);
    settle(12'h064, 12'h000);
    spd(16'h000, 1'b0);
    wr(asrc_pkg::ASRC_REG_SCALE1, 32'h7D0);
    settle(12'h190, 12'h000);
    spd(16'h0C8, 1'b0);
    wr(asrc_pkg::ASRC_REG_OFFSET1, 32'h0);
    settle(12'h1F4, 12'h000);
    rd("demand", asrc_pkg::ASRC_REG_DEMAND, 32'h1F4);
    wr(asrc_pkg::ASRC_REG_SCALE1, 32'h3E8);
    $display("test unipolar done");
  endtask

  task automatic t_modes();
    wr(asrc_pkg::ASRC_REG_FMT1, 32'h1);
    settle(12'hED4, 12'h000);
    spd(16'h096, 1'b1);
    wr(asrc_pkg::ASRC_REG_FMT1, 32'h7);
    settle(12'h000, 12'h000);
    spd(16'h1F4, 1'b0);
    wr(asrc_pkg::ASRC_REG_FMT1, 32'h2);
    settle(12'h12C, 12'h000);
    spd(16'h096, 1'b0);
    wr(asrc_pkg::ASRC_REG_FMT1, 32'h8);
    rd("fmt1", asrc_pkg::ASRC_REG_FMT1, 32'h2);
    $display("test formats done");
  endtask

  // every 4..20 mA and 20..4 mA variant on input 1: loss, status, mask, clear
  task automatic t_loss();
    logic tr;
    wr(asrc_pkg::ASRC_REG_MASK, 32'h1);
    for (int i = 3; i <= 6; i++)
    begin
      tr = (i == 3 || i == 5);
      wr(asrc_pkg::ASRC_REG_FMT1, i);
      settle(12'h258, 12'h000);
      settle(12'h064, 12'h000);
      chk("trip", {31'h0, tr}, {31'h0, trip});
      chk("ramp_stop", {31'h0, !tr}, {31'h0, ramp_stop});
      chk("fault", tr ? 32'h7 : 32'h0, {16'h0, fault_code});
      chk("irq", {31'h0, tr}, {31'h0, irq});
      spd(16'h000, 1'b0);
      rd("status", asrc_pkg::ASRC_REG_STATUS, tr ? 32'h1 : 32'h4);
      settle(12'h258, 12'h000);
      wr(asrc_pkg::ASRC_REG_STATUS, 32'hF);
      settle(12'h258, 12'h000);
      chk("trip", 32'h0, {31'h0, trip});
      chk("irq", 32'h0, {31'h0, irq});
    end
    wr(asrc_pkg::ASRC_REG_FMT1, 32'h0);
    $display("test loop loss done");
  endtask

  task automatic t_ch2();
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h3);
    settle(12'h258, 12'h064);
    chk("fault", 32'h7, {16'h0, fault_code});
    rd("status", asrc_pkg::ASRC_REG_STATUS, 32'h2);
    settle(12'h258, 12'h258);
    wr(asrc_pkg::ASRC_REG_STATUS, 32'hF);
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h8);
    settle(12'h000, 12'h190);
    chk("ain2_level", 32'h0, {21'h0, ain2_level});
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h1);
    rd("fmt2", asrc_pkg::ASRC_REG_FMT2, 32'h8);
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h0);
    settle(12'h000, 12'h190);
    chk("ain2_level", 32'h190, {21'h0, ain2_level});
    wr(asrc_pkg::ASRC_REG_CTRL, 32'h4);
    settle(12'h000, 12'h190);
    spd(16'h0C8, 1'b0);
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h4);
    settle(12'h000, 12'h064);
    chk("ramp_stop", 32'h1, {31'h0, ramp_stop});
    wr(asrc_pkg::ASRC_REG_CTRL, 32'h0);
    wr(asrc_pkg::ASRC_REG_FMT2, 32'h0);
    wr(asrc_pkg::ASRC_REG_STATUS, 32'hF);
    chk("trip", 32'h0, {31'h0, trip});
    $display("test input 2 done");
  endtask

  task automatic t_preset();
    settle(12'h190, 12'h000);
    wr(asrc_pkg::ASRC_REG_CTRL, 32'h1);
    settle(12'h190, 12'h000);
    spd(16'h0F0, 1'b0);
    chk("rpm", 32'h0, {31'h0, speed_in_rpm});
    wr(asrc_pkg::ASRC_REG_RATED, 32'h5DC);
    wr(asrc_pkg::ASRC_REG_PRESET4, 32'hFF9C);
    settle(12'h190, 12'h000);
    chk("rpm", 32'h1, {31'h0, speed_in_rpm});
    spd(16'h064, 1'b1);
    wr(asrc_pkg::ASRC_REG_CTRL, 32'h3);
    settle(12'h190, 12'h000);
    spd(16'h0C8, 1'b0);
    $display("test preset done");
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle(12'h000, 12'h000);
    chk("speed", 32'h0, {16'h0, speed});
    t_reset();
    t_uni();
    t_modes();
    t_loss();
    t_ch2();
    t_preset();
    final_report();
  end
endmodule
